// ---- rtl/sfbs_status.sv ----
// Core status register with flags, reset cause and bank select
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
module sfbs_status (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [6:0] dir_offset,
    output logic [7:0] dir_addr,
    output logic dir_is_status,
    input wire logic alu_valid,
    input wire sfbs_pkg::sfbs_alu_req_t alu_req,
    output logic [7:0] alu_result,
    input wire logic wdt_timeout,
    input wire logic wdt_clear,
    input wire logic sleep_exec,
    output logic [7:0] status_out
);
    logic [7:0] stat_q;
    logic [7:0] stat_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] res_q;
    logic [7:0] res_d;
    sfbs_pkg::sfbs_alu_res_t fres;
    logic wr_hit;
    logic rd_hit;

    function automatic logic is_status_addr(input logic [7:0] a);
        return (a == sfbs_pkg::STAT_ADDR_B0) || (a == sfbs_pkg::STAT_ADDR_B1);
    endfunction

    sfbs_flag_unit u_flags (
        .req(alu_req),
        .carry_in(stat_q[sfbs_pkg::BIT_C]),
        .res(fres)
    );

    assign dir_addr = {stat_q[sfbs_pkg::BIT_RPL], dir_offset};
    assign dir_is_status = is_status_addr(dir_addr);

    assign wr_hit = reg_wr && is_status_addr(reg_addr);
    assign rd_hit = reg_rd && is_status_addr(reg_addr);

    always_comb begin
        stat_d = stat_q;
        res_d = res_q;
        rdata_d = 8'h00;
        if (wr_hit) begin
            stat_d = (stat_q & sfbs_pkg::RO_MASK) |
                     (reg_wdata & ~sfbs_pkg::RO_MASK);
        end
        if (alu_valid) begin
            res_d = fres.result;
            if (fres.upd_z) begin
                stat_d[sfbs_pkg::BIT_Z] = fres.z;
            end
            if (fres.upd_dc) begin
                stat_d[sfbs_pkg::BIT_DC] = fres.dc;
            end
            if (fres.upd_c) begin
                stat_d[sfbs_pkg::BIT_C] = fres.c;
            end
        end
        if (wdt_clear) begin
            stat_d[sfbs_pkg::BIT_TO] = 1'b1;
            stat_d[sfbs_pkg::BIT_PD] = 1'b1;
        end
        if (sleep_exec) begin
            stat_d[sfbs_pkg::BIT_TO] = 1'b1;
            stat_d[sfbs_pkg::BIT_PD] = 1'b0;
        end
        // Time-out is the event, so it wins over a clear in the same cycle
        if (wdt_timeout) begin
            stat_d[sfbs_pkg::BIT_TO] = 1'b0;
        end
        if (rd_hit) begin
            rdata_d = stat_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stat_q <= sfbs_pkg::STAT_RESET;
            rdata_q <= 8'h00;
            res_q <= 8'h00;
        end else begin
            stat_q <= stat_d;
            rdata_q <= rdata_d;
            res_q <= res_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign alu_result = res_q;
    assign status_out = stat_q;

    // Request shapes that the checks below are built from
    sequence s_quiet_write;
        wr_hit && !alu_valid && !wdt_clear && !sleep_exec && !wdt_timeout;
    endsequence

    sequence s_no_update;
        !wr_hit && !alu_valid && !wdt_clear && !sleep_exec &&
            !wdt_timeout;
    endsequence

    sequence s_add_op;
        alu_valid && alu_req.op == sfbs_pkg::SFBS_OP_ADD;
    endsequence

    sequence s_sub_op;
        alu_valid && alu_req.op == sfbs_pkg::SFBS_OP_SUB;
    endsequence

    sequence s_logic_op;
        alu_valid && alu_req.op == sfbs_pkg::SFBS_OP_LOGIC;
    endsequence

    sequence s_rotl_op;
        alu_valid && alu_req.op == sfbs_pkg::SFBS_OP_RLF;
    endsequence

    sequence s_rotr_op;
        alu_valid && alu_req.op == sfbs_pkg::SFBS_OP_RRF;
    endsequence

    sequence s_read_b0;
        reg_rd && reg_addr == sfbs_pkg::STAT_ADDR_B0;
    endsequence

    a_ro_bits_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        (wr_hit && !wdt_clear && !sleep_exec && !wdt_timeout)
        |=> stat_q[4:3] == $past(stat_q[4:3]))
        else $error("reset-cause bits changed by write");

    a_flag_override: assert property (
        @(posedge sys_clk) disable iff (rst)
        (wr_hit && alu_valid && fres.upd_z)
        |=> stat_q[sfbs_pkg::BIT_Z] == $past(fres.z))
        else $error("written zero flag not overridden");

    a_bank_addr: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_hit |=> dir_addr[7] == $past(reg_wdata[sfbs_pkg::BIT_RPL]))
        else $error("direct address bank bit wrong");

    a_bank_zero: assert property (
        @(posedge sys_clk) disable iff (rst)
        (wr_hit && !reg_wdata[sfbs_pkg::BIT_RPL]) |=> dir_addr <= 8'h7f)
        else $error("bank 0 access outside 00h-7Fh");

    a_offset_pass: assert property (
        @(posedge sys_clk) disable iff (rst)
        dir_is_status == (dir_offset == sfbs_pkg::STAT_OFFSET))
        else $error("offset not kept within bank");

    a_alias_read: assert property (
        @(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == sfbs_pkg::STAT_ADDR_B1)
        |=> reg_rdata == $past(stat_q))
        else $error("alias address read mismatch");

    a_sub_borrow: assert property (
        @(posedge sys_clk) disable iff (rst)
        (alu_valid && alu_req.op == sfbs_pkg::SFBS_OP_SUB &&
         alu_req.a < alu_req.b) |=> !stat_q[sfbs_pkg::BIT_C])
        else $error("borrow did not clear carry");

    a_zero_flag: assert property (
        @(posedge sys_clk) disable iff (rst)
        (alu_valid && fres.upd_z)
        |=> stat_q[sfbs_pkg::BIT_Z] == (alu_result == 8'h00))
        else $error("zero flag does not match result");

    a_add_carry: assert property (
        @(posedge sys_clk) disable iff (rst)
        (alu_valid && alu_req.op == sfbs_pkg::SFBS_OP_ADD)
        |=> stat_q[sfbs_pkg::BIT_C] ==
            ((9'($past(alu_req.a)) + 9'($past(alu_req.b))) > 9'h0ff))
        else $error("add carry wrong");

    a_reset_values: assert property (
        @(posedge sys_clk)
        rst |=> status_out == sfbs_pkg::STAT_RESET &&
            reg_rdata == 8'h00 && alu_result == 8'h00)
        else $error("outputs not at reset values");

    a_write_lands: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_quiet_write |=> (stat_q & ~sfbs_pkg::RO_MASK) ==
            ($past(reg_wdata) & ~sfbs_pkg::RO_MASK))
        else $error("status write did not land");

    a_rdata_idle: assert property (
        @(posedge sys_clk) disable iff (rst)
        !rd_hit |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");

    a_alias_read_b0: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_read_b0 |=> reg_rdata == $past(stat_q))
        else $error("bank 0 address read mismatch");

    a_hold_idle: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_no_update |=> $stable(stat_q))
        else $error("status changed with no request");

    a_clear_sets: assert property (
        @(posedge sys_clk) disable iff (rst)
        (wdt_clear && !sleep_exec && !wdt_timeout)
        |=> stat_q[sfbs_pkg::BIT_TO] && stat_q[sfbs_pkg::BIT_PD])
        else $error("watchdog clear did not set both bits");

    a_sleep_flags: assert property (
        @(posedge sys_clk) disable iff (rst)
        (sleep_exec && !wdt_timeout)
        |=> stat_q[sfbs_pkg::BIT_TO] && !stat_q[sfbs_pkg::BIT_PD])
        else $error("sleep did not mark power-down");

    a_timeout_wins: assert property (
        @(posedge sys_clk) disable iff (rst)
        wdt_timeout |=> !stat_q[sfbs_pkg::BIT_TO])
        else $error("time-out did not clear its bit");

    a_add_result: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_add_op |=> alu_result ==
            8'($past(alu_req.a) + $past(alu_req.b)))
        else $error("add result wrong");

    a_add_digit: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_add_op |=> stat_q[sfbs_pkg::BIT_DC] ==
            ((5'($past(alu_req.a[3:0])) + 5'($past(alu_req.b[3:0]))) >
             5'h0f))
        else $error("add digit carry wrong");

    a_sub_digit: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_sub_op ##0 (alu_req.a[3:0] < alu_req.b[3:0])
        |=> !stat_q[sfbs_pkg::BIT_DC])
        else $error("digit borrow did not clear digit carry");

    a_sub_no_borrow: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_sub_op ##0 (alu_req.a >= alu_req.b) |=> stat_q[sfbs_pkg::BIT_C])
        else $error("carry clear without a borrow");

    a_logic_keeps_carry: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_logic_op ##0 !wr_hit
        |=> $stable(stat_q[sfbs_pkg::BIT_DC:sfbs_pkg::BIT_C]))
        else $error("logic op changed carry bits");

    a_rotl_carry: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_rotl_op |=> stat_q[sfbs_pkg::BIT_C] == $past(alu_req.a[7]))
        else $error("rotate left carry wrong");

    a_rotr_carry: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_rotr_op |=> stat_q[sfbs_pkg::BIT_C] == $past(alu_req.a[0]))
        else $error("rotate right carry wrong");

    a_rotl_result: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_rotl_op |=> alu_result ==
            {$past(alu_req.a[6:0]), $past(stat_q[sfbs_pkg::BIT_C])})
        else $error("rotate left result wrong");

    a_rotr_result: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_rotr_op |=> alu_result ==
            {$past(stat_q[sfbs_pkg::BIT_C]), $past(alu_req.a[7:1])})
        else $error("rotate right result wrong");

    a_rotate_keeps_zero: assert property (
        @(posedge sys_clk) disable iff (rst)
        (alu_valid && !wr_hit && (alu_req.op == sfbs_pkg::SFBS_OP_RLF ||
            alu_req.op == sfbs_pkg::SFBS_OP_RRF))
        |=> $stable(stat_q[sfbs_pkg::BIT_Z]))
        else $error("rotate changed the zero flag");

    a_result_held: assert property (
        @(posedge sys_clk) disable iff (rst)
        !alu_valid |=> $stable(alu_result))
        else $error("result changed with no operation");
endmodule

// ---- rtl/sfbs_pkg.sv ----
// Package for the status flags and bank select block
package sfbs_pkg;
    localparam logic [7:0] STAT_ADDR_B0 = 8'h03;
    localparam logic [7:0] STAT_ADDR_B1 = 8'h83;
    localparam logic [6:0] STAT_OFFSET = 7'h03;
    localparam int BANK_BYTES = 128;
    localparam int BIT_IRP = 7;
    localparam int BIT_RPH = 6;
    localparam int BIT_RPL = 5;
    localparam int BIT_TO = 4;
    localparam int BIT_PD = 3;
    localparam int BIT_Z = 2;
    localparam int BIT_DC = 1;
    localparam int BIT_C = 0;
    localparam logic [7:0] STAT_RESET = 8'h18;
    localparam logic [7:0] RO_MASK = 8'h18;
    localparam logic [7:0] FLAG_MASK = 8'h07;

    typedef enum logic [2:0] {
        SFBS_OP_NONE = 3'h0,
        SFBS_OP_ADD = 3'h1,
        SFBS_OP_SUB = 3'h3,
        SFBS_OP_LOGIC = 3'h2,
        SFBS_OP_RLF = 3'h6,
        SFBS_OP_RRF = 3'h7
    } sfbs_op_t;

    typedef struct packed {
        sfbs_op_t op;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] logic_res;
    } sfbs_alu_req_t;

    typedef struct packed {
        logic [7:0] result;
        logic z;
        logic dc;
        logic c;
        logic upd_z;
        logic upd_c;
        logic upd_dc;
    } sfbs_alu_res_t;
endpackage

// ---- rtl/sfbs_flag_unit.sv ----
// Flag generation for add, subtract, logic and rotate results
`timescale 1ns/10ps
module sfbs_flag_unit (
    input wire sfbs_pkg::sfbs_alu_req_t req,
    input wire logic carry_in,
    output sfbs_pkg::sfbs_alu_res_t res
);
    logic [8:0] sum9;
    logic [4:0] sum5;

    always_comb begin
        sum9 = 9'h000;
        sum5 = 5'h00;
        res = '0;
        unique case (req.op)
            sfbs_pkg::SFBS_OP_ADD: begin
                // carry from bit 3 and 7
                sum9 = {1'b0, req.a} + {1'b0, req.b};
                sum5 = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]};
                res.result = sum9[7:0];
                res.c = sum9[8];
                res.dc = sum5[4];
                res.upd_z = 1'b1;
                res.upd_c = 1'b1;
                res.upd_dc = 1'b1;
            end
            sfbs_pkg::SFBS_OP_SUB: begin
                sum9 = {1'b0, req.a} + {1'b0, ~req.b} + 9'h001;
                sum5 = {1'b0, req.a[3:0]} + {1'b0, ~req.b[3:0]} + 5'h01;
                res.result = sum9[7:0];
                res.c = sum9[8];
                res.dc = sum5[4];
                res.upd_z = 1'b1;
                res.upd_c = 1'b1;
                res.upd_dc = 1'b1;
            end
            sfbs_pkg::SFBS_OP_LOGIC: begin
                res.result = req.logic_res;
                res.upd_z = 1'b1;
            end
            sfbs_pkg::SFBS_OP_RLF: begin
                res.result = {req.a[6:0], carry_in};
                res.c = req.a[7];
                res.upd_c = 1'b1;
            end
            sfbs_pkg::SFBS_OP_RRF: begin
                res.result = {carry_in, req.a[7:1]};
                res.c = req.a[0];
                res.upd_c = 1'b1;
            end
            default: begin
                res.result = req.a;
            end
        endcase
        res.z = (res.result == 8'h00);
    end
endmodule

// ---- sim/sfbs_core_model.sv ----
// Core-side model: builds ALU requests and register write data
`timescale 1ns/10ps
module sfbs_core_model (
    input wire sfbs_pkg::sfbs_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic [7:0] raw_wdata,
    output sfbs_pkg::sfbs_alu_req_t alu_req,
    output logic [7:0] reg_wdata
);
    assign reg_wdata = {2'h0, raw_wdata[5:0]};
    // Logic instructions here are an AND of both operands
    assign alu_req = '{op: op, a: a, b: b, logic_res: a & b};
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the status register block
`timescale 1ns/10ps
module tb;
    logic sys_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic alu_valid = 1'h0, wdt_timeout = 1'h0, wdt_clear = 1'h0;
    logic sleep_exec = 1'h0, dir_is_status;
    logic [7:0] reg_addr = '0, raw_wd = '0, a = '0, b = '0, st = 8'h18;
    logic [7:0] reg_wdata, reg_rdata, dir_addr, alu_result, status_out;
    logic [6:0] dir_offset = '0;
    sfbs_pkg::sfbs_op_t op = sfbs_pkg::SFBS_OP_NONE;
    sfbs_pkg::sfbs_alu_req_t alu_req;
    int bad_count = 0, checks = 0, m;
    logic [7:0] adr[4] = '{8'h03, 8'h83, 8'h04, 8'h43};
    sfbs_pkg::sfbs_op_t ops[5] = '{sfbs_pkg::SFBS_OP_ADD,
        sfbs_pkg::SFBS_OP_SUB, sfbs_pkg::SFBS_OP_LOGIC,
        sfbs_pkg::SFBS_OP_RLF, sfbs_pkg::SFBS_OP_RRF};

    sfbs_core_model core_u (.op, .a, .b, .raw_wdata(raw_wd), .alu_req,
        .reg_wdata);
    sfbs_status dut_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .dir_offset, .dir_addr, .dir_is_status,
        .alu_valid, .alu_req, .alu_result, .wdt_timeout, .wdt_clear,
        .sleep_exec, .status_out);

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    task chk(string n, logic [7:0] e, logic [7:0] s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task end_sim;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One request for one cycle, then compare with the model just after the edge that takes it
    task step(bit w, bit r, bit v, logic [2:0] ev, logic [7:0] ad, wd,
            logic [7:0] x, y, sfbs_pkg::sfbs_op_t o);
        logic [7:0] ns, er;
        int rr;
        ns = st;
        rr = 0;
        er = (r && (ad == 8'h03 || ad == 8'h83)) ? st : 8'h00;
        if (w && (ad == 8'h03 || ad == 8'h83))
            ns = {2'h0, wd[5], st[4:3], wd[2:0]};
        if (v) begin
            case (o)
                sfbs_pkg::SFBS_OP_ADD: rr = x + y;
                sfbs_pkg::SFBS_OP_SUB: rr = x - y + 256;
                sfbs_pkg::SFBS_OP_LOGIC: rr = x & y;
                sfbs_pkg::SFBS_OP_RLF: rr = x * 2 + st[0];
                default: rr = (x >> 1) + st[0] * 128 + x[0] * 256;
            endcase
            if (o != sfbs_pkg::SFBS_OP_RLF && o != sfbs_pkg::SFBS_OP_RRF)
                ns[2] = rr % 256 == 0;
            if (o == sfbs_pkg::SFBS_OP_ADD)
                ns[1] = x[3:0] + y[3:0] > 15;
            if (o == sfbs_pkg::SFBS_OP_SUB)
                ns[1] = x[3:0] + 16 - y[3:0] > 15;
            if (o != sfbs_pkg::SFBS_OP_LOGIC)
                ns[0] = rr / 256 % 2;
        end
        if (ev[1])
            ns[4:3] = 2'h3;
        if (ev[0])
            ns[4:3] = 2'h2;
        if (ev[2])
            ns[4] = 1'h0;
        @(posedge sys_clk);
        {reg_wr, reg_rd, alu_valid} <= {w, r, v};
        {wdt_timeout, wdt_clear, sleep_exec} <= ev;
        {reg_addr, raw_wd, a, b} <= {ad, wd, x, y};
        op <= o;
        dir_offset <= ($urandom % 4 == 0) ? 7'h03 : 7'($urandom);
        @(posedge sys_clk);
        {reg_wr, reg_rd, alu_valid} <= 3'h0;
        {wdt_timeout, wdt_clear, sleep_exec} <= 3'h0;
        #1;
        st = ns;
        chk("status", ns, status_out);
        chk("rdata", er, reg_rdata);
        if (v) chk("result", 8'(rr), alu_result);
        chk("dir_addr", {ns[5], dir_offset}, dir_addr);
        chk("is_status", 8'(dir_offset == 3), 8'(dir_is_status));
    endtask

    initial begin
        void'($urandom(32'haabeb9d5));
        repeat (4) @(posedge sys_clk);
        rst <= 1'h0;
        #1;
        chk("reset", 8'h18, status_out);
        for (int i = 0; i < 4; i++) begin
            step(1, 0, 0, 3'h0, adr[i], 8'hff, 8'h00, 8'h00, op);
            step(0, 1, 0, 3'h0, adr[i^1], 8'h00, 8'h00, 8'h00, op);
        end
        step(0, 0, 1, 3'h0, 8'h00, 8'h00, 8'h10, 8'h10, ops[1]);
        step(0, 0, 1, 3'h0, 8'h00, 8'h00, 8'h10, 8'h01, ops[1]);
        step(1, 0, 1, 3'h0, 8'h83, 8'h27, 8'hff, 8'h01, ops[0]);
        step(0, 0, 1, 3'h0, 8'h00, 8'h00, 8'h80, 8'h00, ops[3]);
        step(0, 0, 1, 3'h0, 8'h00, 8'h00, 8'h01, 8'h00, ops[4]);
        for (int k = 1; k < 8; k++)
            step(0, 0, 0, 3'(k), 8'h00, 8'h00, 8'h00, 8'h00, op);
        // Mid-run reset must bring back the reset values
        @(posedge sys_clk);
        rst <= 1'h1;
        @(posedge sys_clk);
        rst <= 1'h0;
        #1;
        st = 8'h18;
        chk("reset", st, status_out);
        chk("reset_rdata", 8'h00, reg_rdata);
        chk("reset_result", 8'h00, alu_result);
        chk("reset_dir", {1'h0, dir_offset}, dir_addr);
        for (int i = 0; i < 400; i++) begin
            m = $urandom % 3;
            step(m == 0, m == 1, 1'($urandom), ($urandom % 8 == 0) ?
                3'($urandom) : 3'h0, adr[$urandom % 4], 8'($urandom),
                8'($urandom), 8'($urandom), ops[$urandom % 5]);
        end
        end_sim;
    end

    initial begin
        #50000;
        bad_count++;
        end_sim;
    end
endmodule
